/* rtl/accessory_detect_consts.vh */
`ifndef ACCESSORY_DETECT_CONSTS_VH
`define ACCESSORY_DETECT_CONSTS_VH

// register indices; byte address is four times the index
`define IDX_CONTROL        6'h02
`define IDX_EVENT_FLAGS    6'h03
`define IDX_EVENT_MASK     6'h05
`define IDX_ID_CODE        6'h07
`define IDX_TIME_SELECT    6'h08
`define IDX_STATUS         6'h09

`define ADDR_W             8
`define DATA_W             32

// reset values
`define RST_CONTROL        8'hD1
`define RST_ZERO           8'h00

// control bits
`define CTL_TIMEOUT_EN     7
`define CTL_RESET_N        6
`define CTL_ID_SENSE_DISABLE         5
`define CTL_MAN_SW         4
`define CTL_INT_BLOCK      0
`define CTL_WR_MASK        8'hB1

// event flag and mask bits
`define EV_OVER_CURRENT    6
`define EV_OVER_VOLTAGE    5
`define EV_MIC_LINE_OVER_VOLTAGE         4
`define EV_ID_CODE         3
`define EV_VBUS_VALID      2
`define EV_CHG_DONE        1
`define EV_USED_MASK       8'h7E

// status bits
`define ST_ID_LINE_SHORTED        7
`define ST_OVER_CURRENT    6
`define ST_OVER_VOLTAGE    5
`define ST_MIC_LINE_OVER_VOLTAGE         4
`define ST_ID_ATTACHED     3
`define ST_VBUS_VALID      2
`define ST_CHG_RUNNING     1
`define ST_CONTACT_SEEN    0

// field widths
`define ID_CODE_W          5
`define TIME_SEL_W         4
`define TIME_SEL_MASK      8'h0F
`define ID_CODE_MASK       8'h1F

// measurement times in ms
`define MEAS_MS_50         50
`define MEAS_MS_STEP_SHORT 50
`define MEAS_MS_STEP_LONG  100
`define MEAS_MS_MAX        1000
`define MEAS_SEL_LONG_BASE 4'h4
`define MEAS_SEL_LAST      4'hB
`define MEAS_MS_LONG_BASE  300

// clock rate in kHz, i.e. cycles per millisecond
`define CLK_KHZ            250000
`define TIMER_W            32

`endif

/* rtl/accessory_detect_event_status_regs.v */
// Overview of operation
// [R01] event flags reset to zero; a read clears exactly the flags it returned
// [R02] bit 6 sets on any change of vbus over-current
// [R03] bit 5 sets on any change of vbus over-voltage
// [R04] bit 4 sets on any change of mic line over-voltage
// [R05] bit 3 sets when the id code changes, never while id sense disabled
// [R06] id code going from non-zero to zero counts as a change
// [R07] bit 2 sets on any toggle of vbus valid
// [R08] bit 1 sets when charger detection finishes; bits 7 and 0 unused
// [R09] mask bits 6..1 suppress interrupt per event; mask resets to zero
// [R10] id code register shows 5-bit measured code, upper bits zero
// [R11] timing register low nibble selects id measurement duration
// [R12] codes 0-3 give 50..200 ms, codes 4-11 give 300..1000 ms
// [R13] reserved timing codes 12-15 use the longest time, 1000 ms
// [R14] status bit 7 shows id line short
// [R15] status bit 6 shows live vbus over-current
// [R16] status bit 5 shows live vbus over-voltage
// [R17] status bit 4 shows live mic over-voltage
// [R18] status bit 3 is one when a resistor sits on the id pin
// [R19] status bit 2 shows vbus valid
// [R20] status bit 1 shows charger detection running
// [R21] status bit 0 holds last contact result; status resets to zero
// [R22] control bit 0 blocks all host interrupts when set
// [R23] control bit 5 stops resistor detection once found; floating still seen
// [R24] host interrupt while any unmasked flag set and block clear
`include "accessory_detect_consts.vh"
`default_nettype none

module accessory_detect_event_status_regs #(
    parameter CYCLES_PER_MS = `CLK_KHZ
) (
    input  wire                    clk,
    input  wire                    resetn,
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [`ADDR_W-1:0]      paddr,
    input  wire [`DATA_W-1:0]      pwdata,
    output reg  [`DATA_W-1:0]      prdata,
    output reg                     pready,
    output reg                     pslverr,
    input  wire                    vbus_over_current,
    input  wire                    vbus_over_voltage,
    input  wire                    mic_line_over_voltage,
    input  wire                    vbus_valid,
    input  wire                    id_line_shorted,
    input  wire [`ID_CODE_W-1:0]   id_pin,
    input  wire                    charger_detect_running,
    input  wire                    charger_detect_done,
    input  wire                    data_contact_seen,
    output reg                     host_irq,
    output reg                     id_sense_disable,
    output reg                     contact_timeout_enable
);

    reg  [7:0]                ctrl_q;
    reg  [7:0]                flags_q;
    reg  [7:0]                mask_q;
    reg  [`ID_CODE_W-1:0]     code_q;
    reg  [`TIME_SEL_W-1:0]    tsel_q;
    reg                       contact_q;
    reg                       oc_prev_q;
    reg                       ov_prev_q;
    reg                       mic_prev_q;
    reg                       vv_prev_q;
    reg  [`ID_CODE_W-1:0]     raw_prev_q;
    reg  [`TIMER_W-1:0]       meas_cnt_q;
    reg  [7:0]                rd_snap_q;

    wire [5:0]                idx = paddr[`ADDR_W-1:2];
    wire                      access = psel & penable & ~pready;
    wire                      done = psel & penable & pready;
    wire                      wr_done = done & pwrite & ~pslverr;
    wire                      rd_flags = done & ~pwrite & ~pslverr & (idx == `IDX_EVENT_FLAGS);
    wire                      mapped;
    wire [7:0]                rd_val;
    wire [7:0]                status_val;
    wire [7:0]                events;
    reg  [`ID_CODE_W-1:0]     code_d;
    reg                       code_chg;

    // [R12] time table in ms
    function [`TIMER_W-1:0] meas_ms;
        input [`TIME_SEL_W-1:0] sel;
        begin
            if (sel < `MEAS_SEL_LONG_BASE) begin
                meas_ms = `MEAS_MS_50 + sel * `MEAS_MS_STEP_SHORT;
            // [R13] reserved codes take longest
            end else if (sel > `MEAS_SEL_LAST) begin
                meas_ms = `MEAS_MS_MAX;
            end else begin
                meas_ms = `MEAS_MS_LONG_BASE + (sel - `MEAS_SEL_LONG_BASE) * `MEAS_MS_STEP_LONG;
            end
        end
    endfunction

    function read_ok;
        input [5:0] i;
        begin
            read_ok = (i == `IDX_CONTROL) || (i == `IDX_EVENT_FLAGS) ||
                      (i == `IDX_EVENT_MASK) || (i == `IDX_ID_CODE) ||
                      (i == `IDX_TIME_SELECT) || (i == `IDX_STATUS);
        end
    endfunction

    assign mapped = read_ok(idx) && (paddr[1:0] == 2'b00);

    // [R14] [R15] [R16] [R17] live status bits
    // [R18] attached means non-zero code
    // [R19] [R20] [R21] vbus, charger, contact
    assign status_val = {id_line_shorted, vbus_over_current, vbus_over_voltage,
                         mic_line_over_voltage, (code_q != {`ID_CODE_W{1'b0}}),
                         vbus_valid, charger_detect_running, contact_q};

    // reset-request bit always reads back as one
    assign rd_val = (idx == `IDX_CONTROL)     ? (ctrl_q | (8'h01 << `CTL_RESET_N)) :
                    (idx == `IDX_EVENT_FLAGS) ? flags_q :
                    (idx == `IDX_EVENT_MASK)  ? mask_q :
                    // [R10] code in low bits
                    (idx == `IDX_ID_CODE)     ? {3'h0, code_q} :
                    // [R11] low nibble only
                    (idx == `IDX_TIME_SELECT) ? {4'h0, tsel_q} :
                    (idx == `IDX_STATUS)      ? status_val : `RST_ZERO;

    // id measurement: raw code must hold for the selected time before it is taken
    always @* begin
        code_d = code_q;
        // [R23] floating is always recognised at once
        if (id_pin == {`ID_CODE_W{1'b0}}) begin
            code_d = {`ID_CODE_W{1'b0}};
        end else if (id_pin == raw_prev_q &&
                     meas_cnt_q >= meas_ms(tsel_q) * CYCLES_PER_MS - 1) begin
            // [R23] disabled sensing keeps a found resistor
            if (!(ctrl_q[`CTL_ID_SENSE_DISABLE] && code_q != {`ID_CODE_W{1'b0}})) begin
                code_d = id_pin;
            end
        end
        // [R05] [R06] any change incl. to zero, blocked while disabled
        code_chg = (code_d != code_q) && !ctrl_q[`CTL_ID_SENSE_DISABLE];
    end

    // [R02] [R03] [R04] [R07] edges in either direction
    // [R08] completion pulse; bits 7 and 0 never set
    assign events = {1'b0,
                     vbus_over_current ^ oc_prev_q,
                     vbus_over_voltage ^ ov_prev_q,
                     mic_line_over_voltage ^ mic_prev_q,
                     code_chg,
                     vbus_valid ^ vv_prev_q,
                     charger_detect_done,
                     1'b0};

    always @(posedge clk) begin
        if (!resetn) begin
            // [R01] flags clear at reset
            flags_q                <= `RST_ZERO;
            // [R09] all unmasked after reset
            mask_q                 <= `RST_ZERO;
            ctrl_q                 <= `RST_CONTROL;
            code_q                 <= {`ID_CODE_W{1'b0}};
            tsel_q                 <= {`TIME_SEL_W{1'b0}};
            contact_q              <= 1'b0;
            oc_prev_q              <= 1'b0;
            ov_prev_q              <= 1'b0;
            mic_prev_q             <= 1'b0;
            vv_prev_q              <= 1'b0;
            raw_prev_q             <= {`ID_CODE_W{1'b0}};
            meas_cnt_q             <= {`TIMER_W{1'b0}};
            rd_snap_q              <= `RST_ZERO;
            prdata                 <= {`DATA_W{1'b0}};
            pready                 <= 1'b0;
            pslverr                <= 1'b0;
            host_irq               <= 1'b0;
            id_sense_disable       <= 1'b0;
            contact_timeout_enable <= 1'b0;
        end else begin
            oc_prev_q  <= vbus_over_current;
            ov_prev_q  <= vbus_over_voltage;
            mic_prev_q <= mic_line_over_voltage;
            vv_prev_q  <= vbus_valid;
            raw_prev_q <= id_pin;
            code_q     <= code_d;
            // restart timing whenever the raw code moves
            if (id_pin != raw_prev_q || code_d != code_q) begin
                meas_cnt_q <= {`TIMER_W{1'b0}};
            end else if (meas_cnt_q != {`TIMER_W{1'b1}}) begin
                meas_cnt_q <= meas_cnt_q + 1'b1;
            end
            // [R21] contact result caught at completion
            if (charger_detect_done) begin
                contact_q <= data_contact_seen;
            end

            // [R01] clear only returned flags; new events win
            if (rd_flags) begin
                flags_q <= ((flags_q & ~rd_snap_q) | events) & `EV_USED_MASK;
            end else begin
                flags_q <= (flags_q | events) & `EV_USED_MASK;
            end

            // apb: one wait state, answer registered
            if (access) begin
                pready    <= 1'b1;
                pslverr   <= ~mapped;
                prdata    <= {{(`DATA_W-8){1'b0}}, (pwrite | ~mapped) ? `RST_ZERO : rd_val};
                rd_snap_q <= flags_q;
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
            if (wr_done) begin
                case (idx)
                    `IDX_CONTROL:     ctrl_q <= pwdata[7:0] & `CTL_WR_MASK;
                    // [R09] mask writable in used bits
                    `IDX_EVENT_MASK:  mask_q <= pwdata[7:0] & `EV_USED_MASK;
                    // [R11] select stored
                    `IDX_TIME_SELECT: tsel_q <= pwdata[`TIME_SEL_W-1:0];
                    default:          ctrl_q <= ctrl_q;
                endcase
            end

            // [R22] [R24] [R09] unmasked flags, not globally blocked
            host_irq <= ~ctrl_q[`CTL_INT_BLOCK] &
                        (|(flags_q & ~mask_q & `EV_USED_MASK));
            id_sense_disable       <= ctrl_q[`CTL_ID_SENSE_DISABLE];
            contact_timeout_enable <= ctrl_q[`CTL_TIMEOUT_EN];
        end
    end

endmodule

`default_nettype wire

/* tb/accessory_detect_event_status_regs_properties.sv */
`include "accessory_detect_consts.vh"
`default_nettype none
module acc_det_checker (
    input wire logic               clk,
    input wire logic               resetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [`DATA_W-1:0] prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               vbus_over_current,
    input wire logic               vbus_over_voltage,
    input wire logic               mic_line_over_voltage,
    input wire logic               vbus_valid,
    input wire logic               host_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] lv;
    assign lv = {vbus_over_current, vbus_over_voltage, mic_line_over_voltage, vbus_valid};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_wait; psel && penable && !pready; endsequence
    sequence s_rd(a); psel && penable && pready && !pwrite && paddr == a; endsequence
    // live inputs held for four samples, so any sampling stage has settled
    sequence s_calm; lv == $past(lv) && lv == $past(lv, 2) && lv == $past(lv, 3); endsequence
    property p_ready_one; s_wait |=> pready; endproperty
    a_ready_one: assert property (p_ready_one) else $error("no answer after one wait");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("slverr without ready");
    property p_zero_data; pready && (pwrite || pslverr) |-> prdata == 32'h0; endproperty
    a_zero_data: assert property (p_zero_data) else $error("data not zero");
    property p_live; s_rd(8'h24) ##0 s_calm |-> {prdata[6:4], prdata[2]} == lv; endproperty
    a_live: assert property (p_live) else $error("status not live");
    property p_unused; s_rd(8'h0C) |-> (prdata & 32'hFFFF_FF81) == 32'h0; endproperty
    a_unused: assert property (p_unused) else $error("unused flag bits set");
    property p_code_w; s_rd(8'h1C) |-> prdata[31:5] == 27'h0; endproperty
    a_code_w: assert property (p_code_w) else $error("code upper bits set");
    property p_irq_fall; $fell(host_irq) |-> $past(pready) || $past(pready, 2); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without access");
endmodule
bind accessory_detect_event_status_regs acc_det_checker chk_u (.clk, .resetn, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .vbus_over_current,
    .vbus_over_voltage, .mic_line_over_voltage, .vbus_valid, .host_irq);
`default_nettype wire

/* tb/apb_host_model.sv */
`default_nettype none
module apb_host_model (
    input  wire logic        clk,
    output var  logic        psel = 1'b0,
    output var  logic        penable = 1'b0,
    output var  logic        pwrite = 1'b0,
    output var  logic [7:0]  paddr = 8'h00,
    output var  logic [31:0] pwdata = 32'h0,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output var  logic        hung = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (!pready && n < 64);
        hung = !pready;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines must not keep looking valid
        paddr <= ~a;
        pwdata <= ~wd;
    endtask
endmodule
`default_nettype wire

/* tb/accessory_detect_event_status_regs_tb_top.sv */
`default_nettype none
module accessory_detect_event_status_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, hung, irq, dis, tmo;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  ev = 4'h0;
    logic [4:0]  id = 5'h00;
    logic        run = 1'b0, done = 1'b0, dcd = 1'b0, shrt = 1'b0;
    logic [7:0]  ra [5] = '{8'h0C, 8'h14, 8'h1C, 8'h20, 8'h24};
    int          bad_count = 0, checks_done = 0;
    always #2 clk = ~clk;
    apb_host_model host_u (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .hung);
    accessory_detect_event_status_regs #(.CYCLES_PER_MS(2)) dut_u (.clk, .resetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .vbus_over_current(ev[0]), .vbus_over_voltage(ev[1]), .mic_line_over_voltage(ev[2]),
        .vbus_valid(ev[3]), .id_line_shorted(shrt), .id_pin(id),
        .charger_detect_running(run), .charger_detect_done(done), .data_contact_seen(dcd),
        .host_irq(irq), .id_sense_disable(dis), .contact_timeout_enable(tmo));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, e,
                       input logic ee);
        logic [31:0] r;
        logic        er;
        host_u.xfer(w, a, d, r, er);
        if (hung) begin
            bad_count++;
            report_and_stop();
        end
        check($sformatf("data at %h", a), e, r);
        check("slverr", {31'h0, ee}, {31'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e); acc(0, a, 0, e, 0); endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d); acc(1, a, d, 0, 0); endtask
    task automatic wt(input int n); repeat (n) @(posedge clk); endtask
    task automatic ci(input logic e); check("irq", {31'h0, e}, {31'h0, irq}); endtask
    function automatic logic [31:0] stat(input logic [7:0] x);
        return {24'h0, shrt, ev[0], ev[1], ev[2], 1'b0, ev[3], 2'b00} | x;
    endfunction
    initial begin
        wt(20);
        resetn <= 1'b1;
        foreach (ra[i]) rd(ra[i], 32'h0);
        rd(8'h08, 32'h0000_00D1);
        acc(0, 8'h04, 0, 0, 1);
        wr(8'h08, 32'h80);
        for (int k = 0; k < 8; k++) begin
            ev[k % 4] <= ~ev[k % 4];
            wt(6);
            ci(1'b1);
            rd(8'h24, stat(8'h00));
            rd(8'h0C, 32'h1 << (k % 4 < 3 ? 6 - k % 4 : 2));
            rd(8'h0C, 32'h0);
            ci(1'b0);
        end
        wr(8'h14, 32'h40);
        ev[0] <= 1'b1;
        wt(6);
        ci(1'b0);
        rd(8'h14, 32'h40);
        rd(8'h0C, 32'h40);
        wr(8'h14, 32'h0);
        wr(8'h08, 32'h81);
        ev[1] <= 1'b1;
        wt(6);
        ci(1'b0);
        wr(8'h08, 32'h80);
        wt(3);
        ci(1'b1);
        rd(8'h0C, 32'h20);
        run <= 1'b1;
        shrt <= 1'b1;
        wt(6);
        rd(8'h24, stat(8'h02));
        run <= 1'b0;
        done <= 1'b1;
        dcd <= 1'b1;
        wt(1);
        done <= 1'b0;
        wt(6);
        rd(8'h0C, 32'h02);
        rd(8'h24, stat(8'h01));
        id <= 5'h0A;
        wt(90);
        rd(8'h1C, 32'h0);
        wt(20);
        rd(8'h1C, 32'h0A);
        rd(8'h0C, 32'h08);
        rd(8'h24, stat(8'h09));
        id <= 5'h00;
        wt(4);
        rd(8'h1C, 32'h0);
        rd(8'h0C, 32'h08);
        wr(8'h20, 32'h0F);
        rd(8'h20, 32'h0F);
        id <= 5'h03;
        wt(1900);
        rd(8'h1C, 32'h0);
        wt(150);
        rd(8'h1C, 32'h03);
        rd(8'h0C, 32'h08);
        wr(8'h08, 32'hA0);
        wt(2);
        check("ctl outs", 32'h3, {30'h0, dis, tmo});
        id <= 5'h00;
        wt(4);
        rd(8'h1C, 32'h0);
        rd(8'h0C, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
